// ==== rxss_pkg.sv ====
// rxss_pkg: constants, types and helpers of the receive slot status builder
// assumes: one system clock, apb register access at 32-bit words
package rxss_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CFG = 8'h00; // buffer channel config
   localparam logic [7:0] ADDR_DFO = 8'h04; // data field offset
   localparam logic [7:0] ADDR_STAT = 8'h08; // receive slot status word

   // ****************************************
   // config field positions
   // ****************************************
   localparam int CFG_LANE_A = 0; // use_first_lane
   localparam int CFG_LANE_B = 1; // use_second_lane
   localparam int CFG_ENABLE = 2; // buffer enabled
   localparam int CFG_STATIC = 3; // buffer lives in the static segment
   localparam int CFG_KIND_LO = 4; // buffer kind, two bits
   localparam int CFG_BITS = 6;

   // buffer kinds
   localparam logic [1:0] KIND_INDIV = 2'h0; // individual receive buffer
   localparam logic [1:0] KIND_FIFO_A = 2'h1; // channel a fifo entry
   localparam logic [1:0] KIND_FIFO_B = 2'h2; // channel b fifo entry

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [5:0] CFG_RST = 6'h00;
   localparam logic [15:0] DFO_RST = 16'h0000;
   localparam logic [15:0] STAT_RST = 16'h0000;

   // slot phase as seen by the builder
   typedef enum logic {PH_IDLE, PH_SLOT} rxss_phase_e;

   // one channel's slot result, packed in status bit order
   typedef struct packed {
      logic valid;   // valid frame seen
      logic sync;    // sync frame indicator
      logic nul;     // null frame indicator
      logic startup; // startup frame indicator
      logic syntax;  // syntax error
      logic content; // content error
      logic bound;   // slot boundary violation
   } rxss_lane_s;

   localparam rxss_lane_s LANE_RST = 7'h00;

   // widen a narrow field into the low bits of an apb word
   function automatic logic [31:0] rxss_word(input logic [15:0] v);
      rxss_word = {16'h0000, v};
   endfunction

endpackage

// ==== rxss_lane_if.sv ====
// rxss_lane_if: one channel's slot result between collector and users
// assumes: driven by exactly one lane collector
`timescale 1ns/10ps
interface rxss_lane_if;
   import rxss_pkg::*;
   rxss_lane_s st; // accumulated slot result
   logic first_hit; // pulse: first valid frame of the slot arrives
   modport src(output st, output first_hit);
   modport dst(input st, input first_hit);
endinterface

// ==== rxss_lane_collect.sv ====
// rxss_lane_collect: gathers one channel's slot evaluation over a slot
// assumes: event inputs are one-cycle pulses from the protocol engine
`timescale 1ns/10ps
module rxss_lane_collect
   import rxss_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // slot framing
   input wire logic slot_start,
   // protocol results
   input wire logic frame_ok,
   input wire logic hdr_sync,
   input wire logic hdr_null,
   input wire logic hdr_startup,
   input wire logic err_syntax,
   input wire logic err_content,
   input wire logic err_bound,
   // result
   rxss_lane_if.src lane
);
   rxss_lane_s st_r, st_nxt;
   logic first_w; // first valid frame in this slot

   // a frame counts as first if no valid frame is held, or the slot restarts
   assign first_w = frame_ok & (slot_start | ~st_r.valid);

   // slot start clears, but events of the same cycle still land
   always_comb begin
      st_nxt = slot_start ? LANE_RST : st_r;
      if (first_w) begin
         // header flags come from the first valid frame only
         st_nxt.valid = 1'b1;
         st_nxt.sync = hdr_sync;
         st_nxt.nul = hdr_null;
         st_nxt.startup = hdr_startup;
      end
      st_nxt.syntax = st_nxt.syntax | err_syntax;
      st_nxt.content = st_nxt.content | err_content;
      st_nxt.bound = st_nxt.bound | err_bound;
   end

   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= LANE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lane.st = st_r;
   assign lane.first_hit = first_w;
endmodule

// ==== rxss_word_pack.sv ====
// rxss_word_pack: lays the two channel results out into the status word
// assumes: layout selects are decoded by the caller
`timescale 1ns/10ps
module rxss_word_pack
   import rxss_pkg::*;
(
   // channel results
   rxss_lane_if.dst la,
   rxss_lane_if.dst lb,
   // layout selects
   input wire logic lay_a,
   input wire logic lay_b,
   input wire logic fvs_ok,
   input wire logic first_b,
   // packed word
   output logic [15:0] word
);
   logic [6:0] hi_w; // channel b field, bits 15..9
   logic [6:0] lo_w; // channel a field, bits 7..1
   logic fvs_w; // first_valid_side

   // bit order of the struct matches valid..boundary
   assign hi_w = lay_b ? lb.st : 7'h00;
   assign lo_w = lay_a ? la.st : 7'h00;
   // zero unless dual static buffer with channel b first
   assign fvs_w = fvs_ok & first_b & lb.st.valid;
   // b in the upper byte, a in the lower, bit 0 unused on receive
   assign word = {hi_w, fvs_w, lo_w, 1'b0};
endmodule

// ==== rxss_slot_status.sv ====
// rxss_slot_status: receive slot status builder with apb register access
// assumes: slot_start/slot_end pulses frame each subscribed slot, and
// the protocol engine drives per-channel result pulses inside the slot
//
// Summary of operation
// - status word is read-only for software
// - dual buffer: b upper, a lower, side bit
// - single-channel buffers and fifos use one layout
// - bit 15 is channel b valid frame
// - bit 14 is channel b sync indicator
// - bit 13 is channel b null indicator
// - bit 12 is channel b startup indicator
// - bit 11 is channel b syntax error
// - bit 10 is channel b content error
// - bit 9 is channel b boundary violation
// - bit 8 only for dual static buffers
// - bit 8 zero if a first or none
// - bit 7 is channel a valid frame
// - bit 6 is channel a sync indicator
// - bit 5 is channel a null indicator
// - bit 4 is channel a startup indicator
// - bit 3 is channel a syntax error
// - bit 2 is channel a content error
// - bit 1 is channel a boundary violation
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module rxss_slot_status
   import rxss_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // protocol state
   input wire logic protocol_setup_state,
   // slot framing
   input wire logic slot_start,
   input wire logic slot_end,
   // channel a results
   input wire logic frame_ok_a,
   input wire logic sync_flag_a,
   input wire logic null_flag_a,
   input wire logic startup_flag_a,
   input wire logic syntax_err_a,
   input wire logic content_err_a,
   input wire logic boundary_viol_a,
   // channel b results
   input wire logic frame_ok_b,
   input wire logic sync_flag_b,
   input wire logic null_flag_b,
   input wire logic startup_flag_b,
   input wire logic syntax_err_b,
   input wire logic content_err_b,
   input wire logic boundary_viol_b,
   // buffer header write
   output logic [15:0] status_word,
   output logic status_wr,
   output logic [15:0] data_offset
);

   // ****************************************
   // registers
   // ****************************************
   logic [5:0] cfg_r; // buffer_channel_config
   logic [15:0] dfo_r; // data field offset
   logic [15:0] stat_r; // receive_slot_status_word
   logic wr_r; // status word written this cycle
   logic first_b_r, first_b_nxt; // channel b delivered first
   logic [31:0] rdata_r; // read data latched in setup
   rxss_phase_e phase_r, phase_nxt;

   // ****************************************
   // channel collectors
   // ****************************************
   rxss_lane_if lane_a();
   rxss_lane_if lane_b();

   // channel a slot accumulation
   rxss_lane_collect u_col_a (
      .clk(clk),
      .arst_n(arst_n),
      .slot_start(slot_start),
      .frame_ok(frame_ok_a),
      .hdr_sync(sync_flag_a),
      .hdr_null(null_flag_a),
      .hdr_startup(startup_flag_a),
      .err_syntax(syntax_err_a),
      .err_content(content_err_a),
      .err_bound(boundary_viol_a),
      .lane(lane_a)
   );

   // channel b slot accumulation
   rxss_lane_collect u_col_b (
      .clk(clk),
      .arst_n(arst_n),
      .slot_start(slot_start),
      .frame_ok(frame_ok_b),
      .hdr_sync(sync_flag_b),
      .hdr_null(null_flag_b),
      .hdr_startup(startup_flag_b),
      .err_syntax(syntax_err_b),
      .err_content(content_err_b),
      .err_bound(boundary_viol_b),
      .lane(lane_b)
   );

   // ****************************************
   // layout decode
   // ****************************************
   logic use_first_lane; // channel a subscribed
   logic use_second_lane; // channel b subscribed
   logic buf_en; // buffer enabled
   logic [1:0] kind_w; // buffer kind
   logic indiv_w; // individual buffer
   logic dual_w; // individual, both channels
   logic fvs_ok_w; // side bit meaningful
   logic lay_a_w; // word carries channel a
   logic lay_b_w; // word carries channel b
   logic [15:0] word_w; // packed status word
   logic cap_w; // capture the word now

   assign use_first_lane = cfg_r[CFG_LANE_A];
   assign use_second_lane = cfg_r[CFG_LANE_B];
   assign buf_en = cfg_r[CFG_ENABLE];
   assign kind_w = cfg_r[CFG_KIND_LO+:2];
   assign indiv_w = (kind_w == KIND_INDIV);
   assign dual_w = indiv_w & use_first_lane & use_second_lane;
   // fifo entries follow their own channel's layout
   assign lay_a_w = (indiv_w & use_first_lane) | (kind_w == KIND_FIFO_A);
   assign lay_b_w = (indiv_w & use_second_lane) | (kind_w == KIND_FIFO_B);
   // side bit only for dual buffers in the static segment
   assign fvs_ok_w = dual_w & cfg_r[CFG_STATIC];

   // lays both channels into one word
   rxss_word_pack u_pack (
      .la(lane_a),
      .lb(lane_b),
      .lay_a(lay_a_w),
      .lay_b(lay_b_w),
      .fvs_ok(fvs_ok_w),
      .first_b(first_b_r),
      .word(word_w)
   );

   // ****************************************
   // slot sequencing
   // ****************************************
   // events in the slot_end cycle are not part of the captured word,
   // the engine is expected to deliver results before slot_end
   assign cap_w = (phase_r == PH_SLOT) & slot_end & buf_en & (lay_a_w | lay_b_w);

   // phase follows slot framing, start wins over end
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         PH_IDLE: begin
            if (slot_start) begin
               phase_nxt = PH_SLOT;
            end
         end
         PH_SLOT: begin
            if (slot_start) begin
               phase_nxt = PH_SLOT;
            end else if (slot_end) begin
               phase_nxt = PH_IDLE;
            end
         end
         default: begin
            phase_nxt = PH_IDLE;
         end
      endcase
   end

   // which channel delivered first; a tie goes to channel a
   always_comb begin
      first_b_nxt = slot_start ? 1'b0 : first_b_r;
      if (lane_b.first_hit & ~lane_a.first_hit & (slot_start | ~lane_a.st.valid)) begin
         first_b_nxt = 1'b1;
      end
      if (lane_a.first_hit & ~slot_start & first_b_r & ~lane_b.st.valid) begin
         first_b_nxt = 1'b0;
      end
   end

   // slot state registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_r <= PH_IDLE;
         first_b_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         first_b_r <= first_b_nxt;
      end
   end

   // status word written by hardware only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stat_r <= STAT_RST;
         wr_r <= 1'b0;
      end else begin
         wr_r <= cap_w;
         if (cap_w) begin
            stat_r <= word_w;
         end
      end
   end

   // ****************************************
   // apb slave
   // ****************************************
   logic setup_w; // first cycle of a transfer
   logic access_w; // completing cycle
   logic hit_cfg, hit_dfo, hit_stat; // address decode
   logic dfo_open; // offset may be written now
   logic bad_w; // error answer
   logic [31:0] rmux_w; // read selection

   assign setup_w = psel & ~penable;
   assign access_w = psel & penable;
   assign hit_cfg = (paddr == ADDR_CFG);
   assign hit_dfo = (paddr == ADDR_DFO);
   assign hit_stat = (paddr == ADDR_STAT);
   // software must not move the offset of a live buffer
   assign dfo_open = protocol_setup_state | ~buf_en;
   // unmapped, write to status, or refused offset write
   assign bad_w = ~(hit_cfg | hit_dfo | hit_stat)
                | (pwrite & hit_stat)
                | (pwrite & hit_dfo & ~dfo_open);
   assign rmux_w = hit_cfg ? {26'h000_0000, cfg_r}
                 : hit_dfo ? rxss_word(dfo_r)
                 : hit_stat ? rxss_word(stat_r)
                 : 32'h0000_0000;

   // zero wait states; error answer comes with the access phase
   assign pready = 1'b1;
   assign pslverr = access_w & bad_w;

   // read data latched in setup so it leaves a flop
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (setup_w) begin
         rdata_r <= pwrite ? 32'h0000_0000 : rmux_w;
      end
   end

   // software registers, refused writes leave them untouched
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r <= CFG_RST;
         dfo_r <= DFO_RST;
      end else if (access_w & pwrite & ~bad_w) begin
         if (hit_cfg) begin
            cfg_r <= pwdata[CFG_BITS-1:0];
         end
         if (hit_dfo) begin
            dfo_r <= pwdata[15:0];
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign prdata = rdata_r;
   assign status_word = stat_r;
   assign status_wr = wr_r;
   assign data_offset = dfo_r;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_valid_b_bit: assert property (wr_r && $past(lay_b_w) |->
      stat_r[15] == $past(lane_b.st.valid))
      else $error("bit 15 differs from channel b valid");
   a_hdr_b_bits: assert property (wr_r && $past(lay_b_w) |->
      stat_r[14:12] == $past({lane_b.st.sync, lane_b.st.nul, lane_b.st.startup}))
      else $error("channel b header bits wrong");
   a_err_b_bits: assert property (wr_r && $past(lay_b_w) |->
      stat_r[11:9] == $past({lane_b.st.syntax, lane_b.st.content, lane_b.st.bound}))
      else $error("channel b error bits wrong");
   a_lane_a_bits: assert property (wr_r && $past(lay_a_w) |->
      stat_r[7:1] == $past(lane_a.st))
      else $error("channel a field wrong");
   // a slot start in the same cycle is left out of the check
   a_err_a_seen: assert property (phase_r == PH_SLOT && !slot_start && syntax_err_a
      |=> lane_a.st.syntax)
      else $error("channel a syntax error lost");
   // each error kept on its own, one cannot stand in for the other
   a_err_a_cb: assert property (!slot_start && (content_err_a || boundary_viol_a)
      |=> (lane_a.st.content || !$past(content_err_a))
      && (lane_a.st.bound || !$past(boundary_viol_a)))
      else $error("channel a error lost");
   a_hdr_a_first: assert property (frame_ok_a && !lane_a.st.valid && !slot_start
      |=> lane_a.st.valid && lane_a.st.startup == $past(startup_flag_a))
      else $error("channel a header not from first frame");
   a_side_none: assert property (wr_r && !$past(lane_b.st.valid) |-> !stat_r[8])
      else $error("side bit set without channel b frame");
   a_side_dual: assert property (wr_r && !$past(fvs_ok_w) |-> !stat_r[8])
      else $error("side bit set outside dual static buffer");
   // b frame first in an open slot, a may follow, then the slot closes
   a_side_first_b: assert property ((frame_ok_b && !frame_ok_a && !lane_a.st.valid
      && !lane_b.st.valid && !slot_start && !slot_end && fvs_ok_w && phase_r == PH_SLOT)
      ##1 (!slot_start && !slot_end) ##1 (slot_end && !slot_start && buf_en)
      |=> stat_r[8])
      else $error("channel b first not flagged");
   a_single_a: assert property (wr_r && $past(kind_w == KIND_FIFO_A) |->
      stat_r[15:8] == 8'h00)
      else $error("fifo a entry carries upper byte");
   a_status_ro: assert property (access_w && pwrite && hit_stat |->
      pslverr ##1 (wr_r || $stable(stat_r)))
      else $error("software changed status word");
   a_dfo_guard: assert property (access_w && pwrite && hit_dfo && !dfo_open |=>
      $stable(dfo_r))
      else $error("offset written while buffer live");

   c_dual_b_first: cover property (wr_r && stat_r[8] && stat_r[7]);
   c_fifo_b: cover property (wr_r && $past(kind_w == KIND_FIFO_B) && stat_r[15]);
   c_dfo_refused: cover property (pslverr && hit_dfo);
   c_errors_both: cover property (wr_r && stat_r[11] && stat_r[3]);

endmodule

// ==== rxss_peer_model.sv ====
// rxss_peer_model: protocol engine stand-in that plays one slot of results
// assumes: the bench calls run_slot between edges, one slot at a time
`timescale 1ns/10ps
module rxss_peer_model
   import rxss_pkg::*;
(
   // clock
   input wire logic clk,
   // slot framing
   output logic slot_start,
   output logic slot_end,
   // per-channel results, in status bit order
   output rxss_lane_s res_a,
   output rxss_lane_s res_b
);
   // ****************************************
   // idle levels at time zero
   // ****************************************
   initial begin
      slot_start = 1'b0;
      slot_end = 1'b0;
      res_a = LANE_RST;
      res_b = LANE_RST;
   end

   // ****************************************
   // one slot: start, errors, frames in order, end
   // ****************************************
   // ord: 0 a first, 1 b first, 2 both in one cycle
   // header bits show inverted outside the frame cycle, so a design that
   // samples them without the frame pulse reads the wrong value
   task automatic run_slot(input rxss_lane_s a, input rxss_lane_s b, input logic [1:0] ord);
      rxss_lane_s fa, fb, ia, ib;
      fa = {a.valid, a[5:3], 3'b000};
      fb = {b.valid, b[5:3], 3'b000};
      ia = {1'b0, ~a[5:3], 3'b000};
      ib = {1'b0, ~b[5:3], 3'b000};
      @(posedge clk);
      slot_start <= 1'b1;
      @(posedge clk);
      slot_start <= 1'b0;
      res_a <= {1'b0, ~a[5:3], a[2:0]};
      res_b <= {1'b0, ~b[5:3], b[2:0]};
      @(posedge clk);
      res_a <= (ord != 2'd1) ? fa : ia;
      res_b <= (ord != 2'd0) ? fb : ib;
      @(posedge clk);
      res_a <= (ord == 2'd1) ? fa : ia;
      res_b <= (ord == 2'd0) ? fb : ib;
      @(posedge clk);
      res_a <= ia;
      res_b <= ib;
      slot_end <= 1'b1;
      @(posedge clk);
      slot_end <= 1'b0;
   endtask
endmodule

// ==== testbench.sv ====
// testbench: self-checking bench of the receive slot status builder
// assumes: rxss_peer_model plays the protocol engine side
`timescale 1ns/10ps
module testbench;
   import rxss_pkg::*;
   // clock, reset, apb
   logic clk, arst_n, psel, penable, pwrite, protocol_setup_state;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, er, status_wr;
   logic [15:0] status_word, data_offset, last_w;
   logic slot_start, slot_end;
   rxss_lane_s res_a, res_b;
   int error_cnt, num_checks;

   rxss_peer_model rxss_peer_model_inst (.clk(clk), .slot_start(slot_start),
      .slot_end(slot_end), .res_a(res_a), .res_b(res_b));

   rxss_slot_status rxss_slot_status_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .protocol_setup_state(protocol_setup_state),
      .slot_start(slot_start), .slot_end(slot_end),
      .frame_ok_a(res_a.valid), .sync_flag_a(res_a.sync), .null_flag_a(res_a.nul),
      .startup_flag_a(res_a.startup), .syntax_err_a(res_a.syntax),
      .content_err_a(res_a.content), .boundary_viol_a(res_a.bound),
      .frame_ok_b(res_b.valid), .sync_flag_b(res_b.sync), .null_flag_b(res_b.nul),
      .startup_flag_b(res_b.startup), .syntax_err_b(res_b.syntax),
      .content_err_b(res_b.content), .boundary_viol_b(res_b.bound),
      .status_word(status_word), .status_wr(status_wr), .data_offset(data_offset));

   // ****************************************
   // clock
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ****************************************
   // reporting
   // ****************************************
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ****************************************
   // apb master: setup, then access until pready
   // ****************************************
   // request held until the edge that samples pready high
   task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                           output logic [31:0] rdv, output logic erv);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         print_verdict();
      end
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   // all registers and outputs at their reset values
   task automatic t_reset;
      apb_xfer(1'b0, ADDR_CFG, 32'h0000_0000, rd, er);
      chk(rd, rxss_word({10'h000, CFG_RST}));
      apb_xfer(1'b0, ADDR_DFO, 32'h0000_0000, rd, er);
      chk(rd, rxss_word(DFO_RST));
      apb_xfer(1'b0, ADDR_STAT, 32'h0000_0000, rd, er);
      chk(rd, rxss_word(STAT_RST));
      chk({status_wr, status_word, data_offset}, 33'h0_0000_0000);
      chk({pready, pslverr}, 2'b10);
   endtask

   // offset writable only in setup state or with the buffer disabled
   task automatic t_offset;
      apb_xfer(1'b1, ADDR_CFG, 32'h0000_0004, rd, er);
      protocol_setup_state <= 1'b0;
      apb_xfer(1'b1, ADDR_DFO, 32'h0000_1234, rd, er);
      chk(er, 1'b1);
      // offset output looked at only once the write edge has settled
      apb_xfer(1'b0, ADDR_DFO, 32'h0000_0000, rd, er);
      chk({er, rd}, 33'h0_0000_0000);
      chk(data_offset, 16'h0000);
      protocol_setup_state <= 1'b1;
      apb_xfer(1'b1, ADDR_DFO, 32'h0000_5678, rd, er);
      chk(er, 1'b0);
      protocol_setup_state <= 1'b0;
      apb_xfer(1'b1, ADDR_CFG, 32'h0000_0000, rd, er);
      chk(data_offset, 16'h5678);
      apb_xfer(1'b1, ADDR_DFO, 32'h0000_abcd, rd, er);
      apb_xfer(1'b0, ADDR_DFO, 32'h0000_0000, rd, er);
      chk({er, rd}, 33'h0_0000_abcd);
      apb_xfer(1'b0, 8'h0c, 32'h0000_0000, rd, er);
      chk({er, rd}, 33'h1_0000_0000);
   endtask

   // one slot under a given buffer setup; expectation built from the layout
   task automatic slot_case(input logic [5:0] cfg, input rxss_lane_s a, input rxss_lane_s b,
                            input logic [1:0] ord);
      logic [1:0] k;
      logic la, lb, side, cap;
      k = cfg[CFG_KIND_LO +: 2];
      la = (k == KIND_INDIV) ? cfg[CFG_LANE_A] : (k == KIND_FIFO_A);
      lb = (k == KIND_INDIV) ? cfg[CFG_LANE_B] : (k == KIND_FIFO_B);
      side = la & lb & cfg[CFG_STATIC] & b.valid & (!a.valid | ord == 2'd1);
      cap = cfg[CFG_ENABLE] & (la | lb);
      apb_xfer(1'b1, ADDR_CFG, {26'h000_0000, cfg}, rd, er);
      rxss_peer_model_inst.run_slot(a, b, ord);
      #1;
      // header bits only count from a valid frame
      if (!a.valid) a[5:3] = 3'b000;
      if (!b.valid) b[5:3] = 3'b000;
      if (cap) last_w = {lb ? b : 7'h00, side, la ? a : 7'h00, 1'b0};
      chk(status_wr, cap);
      chk(status_word, last_w);
      apb_xfer(1'b0, ADDR_STAT, 32'h0000_0000, rd, er);
      chk(rd, rxss_word(last_w));
   endtask

   // dual static buffer: every bit, every first-frame order
   task automatic t_dual;
      slot_case(6'h0f, 7'h7f, 7'h00, 2'd0);
      slot_case(6'h0f, 7'h00, 7'h7f, 2'd1);
      slot_case(6'h0f, 7'h55, 7'h6a, 2'd0);
      slot_case(6'h0f, 7'h4a, 7'h55, 2'd1);
      slot_case(6'h0f, 7'h6b, 7'h5d, 2'd2);
      slot_case(6'h0f, 7'h07, 7'h3f, 2'd1);
      slot_case(6'h0f, 7'h2a, 7'h15, 2'd0);
   endtask

   // single-channel, fifo and dynamic buffers, then refused captures
   task automatic t_layouts;
      slot_case(6'h05, 7'h6b, 7'h5d, 2'd1);
      slot_case(6'h06, 7'h6b, 7'h5d, 2'd1);
      slot_case(6'h07, 7'h6b, 7'h5d, 2'd1);
      slot_case(6'h14, 7'h59, 7'h7f, 2'd1);
      slot_case(6'h24, 7'h7f, 7'h66, 2'd0);
      slot_case(6'h0b, 7'h7f, 7'h7f, 2'd0);
      slot_case(6'h34, 7'h7f, 7'h7f, 2'd0);
   endtask

   // software cannot write the status word
   task automatic t_readonly;
      apb_xfer(1'b1, ADDR_STAT, 32'h0000_ffff, rd, er);
      chk(er, 1'b1);
      apb_xfer(1'b0, ADDR_STAT, 32'h0000_0000, rd, er);
      chk(rd, rxss_word(last_w));
      chk(status_word, last_w);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      error_cnt = 0;
      num_checks = 0;
      last_w = STAT_RST;
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      protocol_setup_state = 1'b0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_offset();
      t_dual();
      t_layouts();
      t_readonly();
      print_verdict();
   end
endmodule
